/* common/etr_defs.svh */
// constants of the elapsed time and event recorder
// assumes a 20 MHz system clock; included by bare name
`ifndef ETR_DEFS_SVH
`define ETR_DEFS_SVH

`define ETR_CLK_KHZ          20000
`define ETR_TICK_MS          250
`define ETR_TICK_CYC         (`ETR_TICK_MS * `ETR_CLK_KHZ)
`define ETR_DEGLITCH_MS      10
`define ETR_DEGLITCH_CYC     (`ETR_DEGLITCH_MS * `ETR_CLK_KHZ)
`define ETR_NVWRITE_MS       20
`define ETR_NVWRITE_CYC      (`ETR_NVWRITE_MS * `ETR_CLK_KHZ)
`define ETR_REARM_US         10
`define ETR_REARM_CYC        ((`ETR_REARM_US * `ETR_CLK_KHZ + 999) / 1000)
`define ETR_REARM_W          8

`define ETR_IDX_W            4
`define ETR_MEM_DEPTH        16
`define ETR_IDX_ETC          4'h0
`define ETR_IDX_EVT          4'h1
`define ETR_IDX_TLIM         4'h2
`define ETR_IDX_ELIM         4'h3
`define ETR_IDX_CFG          4'h4
`define ETR_IDX_PW           4'h5
`define ETR_IDX_BOOT_LAST    4'h5
`define ETR_IDX_USER_FIRST   4'h8

`define ETR_CFG_POL_BIT      0
`define ETR_CFG_TEN_BIT      1
`define ETR_CFG_EEN_BIT      2
`define ETR_PW_RESET         32'h00000000

`endif

/* common/etr_pkg.sv */
// types of the elapsed time and event recorder
// used by etr_recorder
package etr_pkg;

  typedef enum logic [2:0] {
    ST_BOOT,
    ST_IDLE,
    ST_SAVE_T,
    ST_SAVE_E,
    ST_BUSY
  } etr_state_t;

  typedef struct packed {
    logic event_en;
    logic time_en;
    logic polarity;
  } etr_cfg_t;

  typedef struct packed {
    logic [3:0]  idx;
    logic [31:0] data;
  } etr_word_t;

endpackage

/* rtl/etr_nv_mem.sv */
// nonvolatile word store: one write port, one registered read port
// assumes its array survives rstn_in, as the cells would
`timescale 1ns/100ps
`default_nettype none
`include "etr_defs.svh"

module etr_nv_mem (
  input  wire logic        sys_clk_in,
  input  wire logic        rstn_in,
  input  wire logic        wr_en_in,
  input  wire logic [3:0]  wr_idx_in,
  input  wire logic [31:0] wr_data_in,
  input  wire logic [3:0]  rd_idx_in,
  output logic      [31:0] rd_data_out
);

  logic [31:0] cell_reg [`ETR_MEM_DEPTH];

  // blank part reads as zero
  initial begin
    for (int i = 0; i < `ETR_MEM_DEPTH; i++) begin
      cell_reg[i] = 32'h00000000;
    end
  end

  // no reset, contents persist; plain always as the blank fill writes it too
  always @(posedge sys_clk_in) begin
    if (wr_en_in) begin
      cell_reg[wr_idx_in] <= wr_data_in;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rd_data_out <= 32'h00000000;
    end else begin
      rd_data_out <= cell_reg[rd_idx_in];
    end
  end

endmodule // etr_nv_mem
`default_nettype wire

/* rtl/etr_recorder.sv */
// elapsed time and event recorder: deglitch, counters, alarm, store
// assumes a 20 MHz clock, an async pin on event_in, a host on same clock
//
// Operation
// RQ1: falling activity edge adds one to events
// RQ2: 32-bit time counter, one step per 250ms
// RQ3: time counts only while activity is high
// RQ4: alarm when time reaches time limit
// RQ5: alarm when events reach event limit
// RQ6: alarm pin polarity chosen by config bit
// RQ7: counters, limits, settings kept in nonvolatile store
// RQ8: sixteen bytes of user nonvolatile memory; store gives eight 32-bit user words, indices 8 to 15
// RQ9: writes need the four byte password
// RQ10: programming starts at stop, lasts 20ms
// RQ11: alarm returns 10 to 150us after clear
// RQ12: activity input deglitched before use
// RQ13: on fall stop timing, count, store both
// RQ14: writes refused while activity high, reads served
// RQ15: alarm latched until condition gone and cleared
// RQ16: quarter second tick alone enables time steps
// RQ17: limits compared live, each behind its enable
`timescale 1ns/100ps
`default_nettype none
`include "etr_defs.svh"

module etr_recorder #(
  parameter int unsigned TICK_CYC     = `ETR_TICK_CYC,
  parameter int unsigned DEGLITCH_CYC = `ETR_DEGLITCH_CYC,
  parameter int unsigned NVWRITE_CYC  = `ETR_NVWRITE_CYC
) (
  input  wire logic        sys_clk_in,
  input  wire logic        rstn_in,
  input  wire logic        event_in,
  input  wire logic        alarm_clear_command_bit_in,
  input  wire logic        stop_in,
  input  wire logic        wr_req_in,
  input  wire logic [3:0]  wr_idx_in,
  input  wire logic [31:0] wr_data_in,
  input  wire logic [31:0] wr_key_in,
  input  wire logic        rd_req_in,
  input  wire logic [3:0]  rd_idx_in,
  output logic             alarm_pin_out,
  output logic             alarm_oe_out,
  output logic             alarm_active_out,
  output logic             wr_ack_out,
  output logic             wr_nak_out,
  output logic             rd_valid_out,
  output logic      [31:0] rd_data_out,
  output logic             busy_out,
  output logic             event_level_out,
  output logic      [31:0] elapsed_time_out,
  output logic      [15:0] event_count_out
);

  ////////////////////////////////////////////////////////////////////////
  // activity input: three flops, then a stability filter

  logic [2:0]  sync_reg;
  logic        evt_hi_reg;
  logic [22:0] glitch_cnt_reg;
  wire         sync_agree = (sync_reg[1] == sync_reg[2]);
  wire         sync_diff  = sync_agree && (sync_reg[2] != evt_hi_reg);
  wire         glitch_done = (glitch_cnt_reg == 23'(DEGLITCH_CYC - 1));
  wire         evt_flip   = sync_diff && glitch_done;
  wire         evt_rise   = evt_flip && !evt_hi_reg;
  wire         evt_fall   = evt_flip && evt_hi_reg;

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sync_reg       <= 3'h0;
      evt_hi_reg     <= 1'b0;
      glitch_cnt_reg <= 23'h000000;
    end else begin
      sync_reg       <= {sync_reg[1:0], event_in};
      // spikes shorter than the filter restart it
      glitch_cnt_reg <= (sync_diff && !glitch_done) ?
                        glitch_cnt_reg + 23'h000001 : 23'h000000; // RQ12
      if (evt_flip) begin
        evt_hi_reg <= !evt_hi_reg; // RQ12
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // working counters and quarter second tick

  etr_pkg::etr_state_t state_reg;
  logic [22:0] tick_cnt_reg;
  logic [31:0] etc_reg;
  logic [15:0] evt_reg;
  logic [31:0] tlim_reg;
  logic [15:0] elim_reg;
  logic [31:0] pw_reg;
  etr_pkg::etr_cfg_t cfg_reg;
  wire         tick = evt_hi_reg && (tick_cnt_reg == 23'(TICK_CYC - 1));

  // boot and program loads into the working copies
  logic        load_en;
  logic [3:0]  load_idx;
  logic [31:0] load_data;
  wire ld_etc  = load_en && (load_idx == `ETR_IDX_ETC);
  wire ld_evt  = load_en && (load_idx == `ETR_IDX_EVT);
  wire ld_tlim = load_en && (load_idx == `ETR_IDX_TLIM);
  wire ld_elim = load_en && (load_idx == `ETR_IDX_ELIM);
  wire ld_cfg  = load_en && (load_idx == `ETR_IDX_CFG);
  wire ld_pw   = load_en && (load_idx == `ETR_IDX_PW);

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      tick_cnt_reg <= 23'h000000;
    end else if (!evt_hi_reg || tick) begin
      tick_cnt_reg <= 23'h000000; // RQ16
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 23'h000001; // RQ16
    end
  end

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      etc_reg  <= 32'h00000000;
      evt_reg  <= 16'h0000;
      tlim_reg <= 32'h00000000;
      elim_reg <= 16'h0000;
      pw_reg   <= `ETR_PW_RESET;
      cfg_reg  <= '0;
    end else begin
      if (ld_etc) begin
        etc_reg <= load_data;
      end else if (tick) begin
        etc_reg <= etc_reg + 32'h00000001; // RQ2 RQ3
      end
      if (ld_evt) begin
        evt_reg <= load_data[15:0];
      end else if (evt_fall) begin
        evt_reg <= evt_reg + 16'h0001; // RQ1 RQ13
      end
      if (ld_tlim) tlim_reg <= load_data;
      if (ld_elim) elim_reg <= load_data[15:0];
      if (ld_pw) pw_reg <= load_data;
      if (ld_cfg) begin
        cfg_reg <= {load_data[`ETR_CFG_EEN_BIT],
                    load_data[`ETR_CFG_TEN_BIT],
                    load_data[`ETR_CFG_POL_BIT]};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // store sequencing

  logic [3:0]  boot_idx_reg;
  logic [3:0]  boot_ld_idx_reg;
  logic        boot_vld_reg;
  logic        fall_pend_reg;
  logic        pend_reg;
  etr_pkg::etr_word_t pend_word_reg;
  logic [18:0] busy_cnt_reg;
  logic        mem_wr_en;
  logic [3:0]  mem_wr_idx;
  logic [31:0] mem_wr_data;
  logic [3:0]  mem_rd_idx;
  logic [31:0] mem_rd_data;
  etr_pkg::etr_state_t state_next;

  wire busy_done = (busy_cnt_reg == 19'(NVWRITE_CYC - 1));
  wire boot_last = (boot_ld_idx_reg == `ETR_IDX_BOOT_LAST);
  wire idle      = (state_reg == etr_pkg::ST_IDLE);
  wire prog_go   = idle && pend_reg && stop_in && !evt_fall; // RQ10

  // key must match the stored password
  wire key_ok    = (wr_key_in == pw_reg); // RQ9
  // a write meeting the rising edge is refused, never left pending
  wire wr_ok     = idle && !evt_hi_reg && !evt_rise &&
                   !pend_reg && key_ok; // RQ14

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      etr_pkg::ST_BOOT:   if (boot_vld_reg && boot_last)
                            state_next = etr_pkg::ST_IDLE;
      etr_pkg::ST_IDLE:   if (evt_fall) state_next = etr_pkg::ST_SAVE_T;
                          else if (prog_go) state_next = etr_pkg::ST_BUSY;
      etr_pkg::ST_SAVE_T: state_next = etr_pkg::ST_SAVE_E;
      etr_pkg::ST_SAVE_E: state_next = etr_pkg::ST_BUSY;
      etr_pkg::ST_BUSY:   if (busy_done)
                            state_next = fall_pend_reg ?
                                         etr_pkg::ST_SAVE_T :
                                         etr_pkg::ST_IDLE;
      default:            state_next = etr_pkg::ST_IDLE;
    endcase
  end

  // write port: counter saves on fall, else the pending host word
  wire save_t = (state_reg == etr_pkg::ST_SAVE_T);
  wire save_e = (state_reg == etr_pkg::ST_SAVE_E);
  assign mem_wr_en   = save_t || save_e || prog_go; // RQ7 RQ13
  assign mem_wr_idx  = save_t ? `ETR_IDX_ETC :
                       save_e ? `ETR_IDX_EVT : pend_word_reg.idx;
  assign mem_wr_data = save_t ? etc_reg :
                       save_e ? {16'h0000, evt_reg} : pend_word_reg.data;
  assign mem_rd_idx  = (state_reg == etr_pkg::ST_BOOT) ?
                       boot_idx_reg : rd_idx_in;
  assign load_en     = (boot_vld_reg && (state_reg == etr_pkg::ST_BOOT)) ||
                       prog_go;
  assign load_idx    = prog_go ? pend_word_reg.idx : boot_ld_idx_reg;
  assign load_data   = prog_go ? pend_word_reg.data : mem_rd_data;

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_reg     <= etr_pkg::ST_BOOT;
      boot_idx_reg  <= 4'h0;
      boot_ld_idx_reg <= 4'h0;
      boot_vld_reg  <= 1'b0;
      fall_pend_reg <= 1'b0;
      pend_reg      <= 1'b0;
      pend_word_reg <= '0;
      busy_cnt_reg  <= 19'h00000;
    end else begin
      state_reg    <= state_next;
      boot_vld_reg <= (state_reg == etr_pkg::ST_BOOT);
      // store read lags its address one edge, so the load index trails it
      boot_ld_idx_reg <= boot_idx_reg;
      if ((state_reg == etr_pkg::ST_BOOT) &&
          (boot_idx_reg != `ETR_IDX_BOOT_LAST)) begin
        boot_idx_reg <= boot_idx_reg + 4'h1;
      end
      // a fall during a program cycle, except in its last cycle, is saved once it ends
      if (evt_fall && !idle) begin
        fall_pend_reg <= 1'b1; // RQ13
      end else if (save_t) begin
        fall_pend_reg <= 1'b0;
      end
      if (wr_req_in && wr_ok) begin
        pend_reg      <= 1'b1;
        pend_word_reg <= '{idx: wr_idx_in, data: wr_data_in};
      end else if (prog_go || evt_rise) begin
        pend_reg      <= 1'b0; // RQ10 RQ14
      end
      busy_cnt_reg <= (state_reg == etr_pkg::ST_BUSY && !busy_done) ?
                      busy_cnt_reg + 19'h00001 : 19'h00000; // RQ10
    end
  end

  etr_nv_mem u_mem (
    .sys_clk_in  (sys_clk_in),
    .rstn_in     (rstn_in),
    .wr_en_in    (mem_wr_en),
    .wr_idx_in   (mem_wr_idx),
    .wr_data_in  (mem_wr_data),
    .rd_idx_in   (mem_rd_idx),
    .rd_data_out (mem_rd_data)
  ); // RQ7 RQ8

  ////////////////////////////////////////////////////////////////////////
  // host reads: counters come live, password never leaves

  logic        rd_stage_reg;
  logic [3:0]  rd_sel_reg;
  wire         rd_go = rd_req_in && (state_reg != etr_pkg::ST_BOOT);
  wire [31:0]  rd_mux =
    (rd_sel_reg == `ETR_IDX_ETC)  ? etc_reg :
    (rd_sel_reg == `ETR_IDX_EVT)  ? {16'h0000, evt_reg} :
    (rd_sel_reg == `ETR_IDX_TLIM) ? tlim_reg :
    (rd_sel_reg == `ETR_IDX_ELIM) ? {16'h0000, elim_reg} :
    (rd_sel_reg == `ETR_IDX_CFG)  ? {29'h00000000, cfg_reg} :
    (rd_sel_reg == `ETR_IDX_PW)   ? 32'h00000000 : mem_rd_data;

  ////////////////////////////////////////////////////////////////////////
  // alarm: live compare, latch, rearm delay after clear

  logic        alarm_reg;
  logic [7:0]  rearm_cnt_reg;
  wire t_hit = cfg_reg.time_en && (etc_reg >= tlim_reg); // RQ4 RQ17
  wire e_hit = cfg_reg.event_en && (evt_reg >= elim_reg); // RQ5 RQ17
  wire cond  = t_hit || e_hit;
  wire rearm = (rearm_cnt_reg != 8'h00);
  wire alarm_next = alarm_clear_command_bit_in ? 1'b0 :
                    (rearm ? 1'b0 : (alarm_reg || cond)); // RQ15
  // polarity 0 sinks on alarm, 1 releases on alarm
  wire oe_next = cfg_reg.polarity ? !alarm_next : alarm_next; // RQ6

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      alarm_reg     <= 1'b0;
      rearm_cnt_reg <= 8'h00;
      alarm_oe_out  <= 1'b0;
    end else begin
      alarm_reg     <= alarm_next;
      alarm_oe_out  <= oe_next;
      // output drops, then returns if a limit still holds
      if (alarm_clear_command_bit_in) begin
        rearm_cnt_reg <= `ETR_REARM_W'(`ETR_REARM_CYC); // RQ11
      end else if (rearm) begin
        rearm_cnt_reg <= rearm_cnt_reg - 8'h01; // RQ11
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registered outputs

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      alarm_pin_out    <= 1'b0;
      alarm_active_out <= 1'b0;
      wr_ack_out       <= 1'b0;
      wr_nak_out       <= 1'b0;
      rd_stage_reg     <= 1'b0;
      rd_sel_reg       <= 4'h0;
      rd_valid_out     <= 1'b0;
      rd_data_out      <= 32'h00000000;
      busy_out         <= 1'b1;
      event_level_out  <= 1'b0;
      elapsed_time_out <= 32'h00000000;
      event_count_out  <= 16'h0000;
    end else begin
      alarm_pin_out    <= 1'b0;
      alarm_active_out <= alarm_next;
      wr_ack_out       <= wr_req_in && wr_ok;
      wr_nak_out       <= wr_req_in && !wr_ok; // RQ9 RQ14
      rd_stage_reg     <= rd_go;
      if (rd_go) rd_sel_reg <= rd_idx_in;
      rd_valid_out     <= rd_stage_reg; // RQ14
      if (rd_stage_reg) rd_data_out <= rd_mux;
      busy_out         <= (state_next != etr_pkg::ST_IDLE) || evt_hi_reg;
      event_level_out  <= evt_hi_reg;
      elapsed_time_out <= etc_reg;
      event_count_out  <= evt_reg;
    end
  end

endmodule // etr_recorder
`default_nettype wire

/* tb/etr_monitor.sv */
// checker for etr_recorder, sees only its ports
// bound from the testbench top file
`timescale 1ns/100ps
`default_nettype none
module etr_monitor (
  input wire logic        sys_clk_in,
  input wire logic        rstn_in,
  input wire logic        alarm_clear_command_bit_in,
  input wire logic        stop_in,
  input wire logic        wr_req_in,
  input wire logic        rd_req_in,
  input wire logic        alarm_pin_out,
  input wire logic        alarm_oe_out,
  input wire logic        alarm_active_out,
  input wire logic        wr_ack_out,
  input wire logic        wr_nak_out,
  input wire logic        rd_valid_out,
  input wire logic        busy_out,
  input wire logic        event_level_out,
  input wire logic [31:0] elapsed_time_out,
  input wire logic [15:0] event_count_out
);
  logic        booted_reg;
  logic [11:0] since_clr_reg;
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rstn_in);
  // boot loads working copies, so step checks wait for it
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) booted_reg <= 1'b0;
    else if (!busy_out) booted_reg <= 1'b1;
  end
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) since_clr_reg <= 12'hFFF;
    else if (alarm_clear_command_bit_in) since_clr_reg <= 12'h000;
    else if (since_clr_reg != 12'hFFF) since_clr_reg <= since_clr_reg + 12'h001;
  end
  sequence s_write_taken;
    wr_ack_out ##1 stop_in;
  endsequence
  sequence s_read_asked;
    booted_reg && rd_req_in;
  endsequence
  a_pin_low:
    assert property (!alarm_pin_out) else $error("alarm pin data not low");
  a_oe_follows:
    assert property (booted_reg && $changed(alarm_active_out) && !$past(stop_in)
      |-> $changed(alarm_oe_out)) else $error("alarm enable did not follow");
  a_event_step:
    assert property (booted_reg && $changed(event_count_out) && !$past(stop_in)
      |-> event_count_out == $past(event_count_out) + 16'h0001)
      else $error("event count step not one");
  a_time_hold:
    assert property (booted_reg && !event_level_out && !$past(event_level_out)
      && !$past(stop_in) |-> $stable(elapsed_time_out))
      else $error("time moved while inactive");
  a_time_step:
    assert property (booted_reg && $changed(elapsed_time_out) && !$past(stop_in)
      |-> elapsed_time_out == $past(elapsed_time_out) + 32'h1
      ##1 $stable(elapsed_time_out)[*8]) else $error("time step wrong");
  a_active_nak:
    assert property (wr_req_in && event_level_out |=> wr_nak_out)
      else $error("write not refused while active");
  a_read_served:
    assert property (s_read_asked |-> ##2 rd_valid_out)
      else $error("read not answered");
  a_prog_busy:
    assert property (s_write_taken |=> busy_out[*8])
      else $error("no programming after stop");
  a_latch_hold:
    assert property ($fell(alarm_active_out) |-> $past(alarm_clear_command_bit_in)
      || $past(alarm_clear_command_bit_in, 2)) else $error("alarm dropped unasked");
  a_rearm_floor:
    assert property ($rose(alarm_active_out) |-> since_clr_reg >= 12'h0C8)
      else $error("alarm back too soon");
endmodule // etr_monitor
`default_nettype wire

/* tb/etr_host_model.sv */
// host model: write, stop and read cycles on the recorder port
// same clock; drives 1 ns after the rising edge
`timescale 1ns/100ps
`default_nettype none
module etr_host_model (
  input  wire logic        sys_clk_in,
  input  wire logic        busy_in,
  input  wire logic        ack_in,
  input  wire logic        nak_in,
  input  wire logic        valid_in,
  input  wire logic [31:0] rdata_in,
  output logic             stop_out,
  output logic             wr_req_out,
  output logic             rd_req_out,
  output logic      [3:0]  idx_out,
  output logic      [31:0] data_out,
  output logic      [31:0] key_out
);
  initial begin
    {stop_out, wr_req_out, rd_req_out} = 3'h0;
    idx_out = 4'h0;
    data_out = 32'h0;
    key_out = 32'h0;
  end
  task automatic step();
    @(posedge sys_clk_in);
    #1;
  endtask
  task automatic wr(input logic [3:0] i, input logic [31:0] d, k,
                    output logic [1:0] ans, output int busy_n);
    step();
    idx_out = i;
    data_out = d;
    key_out = k;
    wr_req_out = 1'b1;
    step();
    wr_req_out = 1'b0;
    // answer stands one cycle, taken while it stands
    ans = {ack_in, nak_in};
    data_out = ~d;
    key_out = ~k;
    busy_n = 0;
    if (ans[1]) begin
      step();
      stop_out = 1'b1;
      step();
      stop_out = 1'b0;
      busy_n = busy_in;
      // no new write until programming is over
      while (busy_in && busy_n < 200) begin
        step();
        busy_n += busy_in;
      end
    end
  endtask
  task automatic rd(input logic [3:0] i, output logic [31:0] d,
                    output logic v);
    step();
    idx_out = i;
    rd_req_out = 1'b1;
    step();
    rd_req_out = 1'b0;
    step();
    v = valid_in;
    d = rdata_in;
  endtask
endmodule // etr_host_model
`default_nettype wire

/* tb/testbench.sv */
// self-checking bench for etr_recorder driven by the host model
// counts shortened: tick 20, deglitch 4, nv write 10 cycles
`timescale 1ns/100ps
`default_nettype none
module testbench;
  localparam int unsigned NVW = 10;
  localparam logic [31:0] PW = 32'hA5C3_0F19;
  logic        sys_clk_in, rstn_in, event_in, clr, stop, wreq, rreq;
  logic        pin, oe, act, ack, nak, vld, busy, lvl, v;
  logic [3:0]  idx;
  logic [31:0] wdata, key, rdata, tcount, d;
  logic [15:0] ecount;
  logic [1:0]  ans;
  int          busy_n, errors, n_compared;
  etr_recorder #(.TICK_CYC(20), .DEGLITCH_CYC(4), .NVWRITE_CYC(NVW))
    etr_recorder_i (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in),
    .event_in(event_in), .alarm_clear_command_bit_in(clr), .stop_in(stop),
    .wr_req_in(wreq), .wr_idx_in(idx), .wr_data_in(wdata), .wr_key_in(key),
    .rd_req_in(rreq), .rd_idx_in(idx), .alarm_pin_out(pin),
    .alarm_oe_out(oe), .alarm_active_out(act), .wr_ack_out(ack),
    .wr_nak_out(nak), .rd_valid_out(vld), .rd_data_out(rdata),
    .busy_out(busy), .event_level_out(lvl), .elapsed_time_out(tcount),
    .event_count_out(ecount));
  etr_host_model etr_host_model_i (.sys_clk_in(sys_clk_in), .busy_in(busy),
    .ack_in(ack), .nak_in(nak), .valid_in(vld), .rdata_in(rdata),
    .stop_out(stop), .wr_req_out(wreq), .rd_req_out(rreq), .idx_out(idx),
    .data_out(wdata), .key_out(key));
  initial begin
    sys_clk_in = 1'b0;
    forever #25 sys_clk_in = ~sys_clk_in;
  end
  task automatic check(input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_in);
    #1;
  endtask
  // which: 1 filtered level, 0 busy
  task automatic wait_until(input logic which, input logic want);
    int k;
    k = 0;
    while ((which ? lvl : busy) !== want && k < 60) begin
      cyc(1);
      k++;
    end
    if ((which ? lvl : busy) !== want) begin
      errors++;
      wrap_up();
    end
  endtask
  task automatic put(input logic [3:0] i, input logic [31:0] dd, kk,
                     input logic ok);
    etr_host_model_i.wr(i, dd, kk, ans, busy_n);
    check(ans, ok ? 32'h2 : 32'h1);
    if (ok) check(busy_n, NVW);
  endtask
  task automatic get(input logic [3:0] i, input logic [31:0] exp);
    etr_host_model_i.rd(i, d, v);
    check(v, 32'h1);
    check(d, exp);
  endtask
  task automatic do_reset();
    rstn_in = 1'b0;
    cyc(6);
    rstn_in = 1'b1;
    cyc(1);
    wait_until(1'b0, 1'b0);
  endtask
  task automatic clear_pulse(input int settle);
    clr = 1'b1;
    cyc(1);
    clr = 1'b0;
    cyc(settle);
  endtask
  initial begin
    rstn_in = 1'b0;
    event_in = 1'b0;
    clr = 1'b0;
    errors = 0;
    n_compared = 0;
    do_reset();
    get(4'h0, 32'h0);
    get(4'h5, 32'h0);
    put(4'h8, 32'hC0DE_0008, 32'h0, 1'b1);
    put(4'hB, 32'hC0DE_000B, 32'h0, 1'b1);
    get(4'hB, 32'hC0DE_000B);
    put(4'h5, PW, 32'h0, 1'b1);
    put(4'h9, 32'h1, 32'h0, 1'b0);
    event_in = 1'b1;
    cyc(2);
    event_in = 1'b0;
    cyc(12);
    check(lvl, 32'h0);
    check(ecount, 32'h0);
    event_in = 1'b1;
    wait_until(1'b1, 1'b1);
    put(4'h9, 32'h1, PW, 1'b0);
    get(4'h8, 32'hC0DE_0008);
    cyc(58);
    check(tcount, 32'h3);
    event_in = 1'b0;
    wait_until(1'b1, 1'b0);
    check(ecount, 32'h1);
    cyc(30);
    check(tcount, 32'h3);
    wait_until(1'b0, 1'b0);
    do_reset();
    get(4'h0, 32'h3);
    get(4'h1, 32'h1);
    put(4'h2, 32'h3, PW, 1'b1);
    put(4'h4, 32'h2, PW, 1'b1);
    cyc(2);
    check(act, 32'h1);
    check(oe, 32'h1);
    clear_pulse(100);
    check(act, 32'h0);
    cyc(2899);
    check(act, 32'h1);
    put(4'h4, 32'h3, PW, 1'b1);
    cyc(2);
    check(oe, 32'h0);
    check(pin, 32'h0);
    put(4'h3, 32'h1, PW, 1'b1);
    put(4'h4, 32'h4, PW, 1'b1);
    clear_pulse(300);
    check(act, 32'h1);
    put(4'h3, 32'h5, PW, 1'b1);
    clear_pulse(300);
    check(act, 32'h0);
    wrap_up();
  end
endmodule // testbench
bind etr_recorder etr_monitor etr_monitor_i (.sys_clk_in(sys_clk_in),
  .rstn_in(rstn_in), .alarm_clear_command_bit_in(alarm_clear_command_bit_in),
  .stop_in(stop_in), .wr_req_in(wr_req_in), .rd_req_in(rd_req_in),
  .alarm_pin_out(alarm_pin_out), .alarm_oe_out(alarm_oe_out),
  .alarm_active_out(alarm_active_out), .wr_ack_out(wr_ack_out),
  .wr_nak_out(wr_nak_out), .rd_valid_out(rd_valid_out), .busy_out(busy_out),
  .event_level_out(event_level_out), .elapsed_time_out(elapsed_time_out),
  .event_count_out(event_count_out));
`default_nettype wire
